//--- common/scpa_pkg.sv
package scpa_pkg;
	// Synchroniser lanes
	localparam int PIN_SCL   = 0;
	localparam int PIN_SDA   = 1;
	localparam int PIN_SS    = 2;
	localparam int PIN_MOSI  = 3;
	localparam int PIN_COUNT = 4;

	localparam logic [15:0] PLL_REG_FIRST  = 16'hf000;
	localparam logic [15:0] PLL_REG_LAST   = 16'hf004;
	localparam logic [15:0] CTRL_REG_BASE  = 16'hf000;
	localparam logic [15:0] CORE_HALT_REG  = 16'hf400;
	localparam logic [15:0] CORE_START_REG = 16'hf402;
	localparam logic [15:0] PAGE_SEL_REG   = 16'hf899;
	localparam logic        PAGE_RESET     = 1'h0;

	localparam logic [4:0] CHIP_ADDR_PREFIX   = 5'h0e;
	localparam logic [1:0] SPI_SWITCH_TOGGLES = 2'h3;
	localparam logic [1:0] STRAP_DELAY        = 2'h2;
	localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

	// Last byte index of a word: control registers 2 bytes, memory 4 bytes
	localparam logic [1:0] CTRL_LAST_BYTE = 2'h1;
	localparam logic [1:0] MEM_LAST_BYTE  = 2'h3;

	// Position of a byte within a transaction
	localparam logic [1:0] CHIP_BYTE_IDX = 2'h0;
	localparam logic [1:0] SUB_HI_IDX    = 2'h1;
	localparam logic [1:0] SUB_LO_IDX    = 2'h2;
	localparam logic [1:0] DATA_BYTE_IDX = 2'h3;

	typedef enum logic [2:0] {
		SCPA_IDLE  = 3'b000,
		SCPA_RX    = 3'b001,
		SCPA_RXACK = 3'b010,
		SCPA_TX    = 3'b011,
		SCPA_TXACK = 3'b100
	} scpa_state_t;
endpackage

//--- src/scpa_slave_port.sv
`timescale 1ns/1ns
module scpa_slave_port #(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic        selectOrStrapZeroPin,
	input  wire logic        serialInOrStrapOnePin,
	input  wire logic        pllLocked,
	input  wire logic        masterClockValid,
	output logic             wrValid,
	input  wire logic        wrReady,
	output logic [15:0]      wrAddr,
	output logic             wrPage,
	output logic             wrIsCtrl,
	output logic [31:0]      wrData,
	output logic             wrDropped,
	output logic [15:0]      rdAddr,
	output logic             rdPage,
	input  wire logic [31:0] rdData,
	output logic             spiMode,
	output logic             upperPageSelect,
	output logic             portBusy
);
	localparam int PTR_W   = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int ENTRY_W = 50;

	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two of at least 2");
	end

	// Two-flop synchronisers; lane A feeds lane B only
	logic [scpa_pkg::PIN_COUNT-1:0] pinRaw;
	logic [scpa_pkg::PIN_COUNT-1:0] syncA;
	logic [scpa_pkg::PIN_COUNT-1:0] syncB;
	logic [scpa_pkg::PIN_COUNT-1:0] syncPrev;

	assign pinRaw = {serialInOrStrapOnePin, selectOrStrapZeroPin, sdaIn, sclIn};

	for (genvar i = 0; i < scpa_pkg::PIN_COUNT; i++) begin : g_sync
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				syncA[i]    <= 1'b1;
				syncB[i]    <= 1'b1;
				syncPrev[i] <= 1'b1;
			end else begin
				syncA[i]    <= pinRaw[i];
				syncB[i]    <= syncA[i];
				syncPrev[i] <= syncB[i];
			end
		end
	end

	logic sclS, sclP, sdaS, sdaP, ssS, ssP, mosiS;
	assign sclS  = syncB[scpa_pkg::PIN_SCL];
	assign sclP  = syncPrev[scpa_pkg::PIN_SCL];
	assign sdaS  = syncB[scpa_pkg::PIN_SDA];
	assign sdaP  = syncPrev[scpa_pkg::PIN_SDA];
	assign ssS   = syncB[scpa_pkg::PIN_SS];
	assign ssP   = syncPrev[scpa_pkg::PIN_SS];
	assign mosiS = syncB[scpa_pkg::PIN_MOSI];

	// Strap capture a few cycles after reset release, once the synchronisers hold pin levels
	logic [1:0] strapCnt;
	logic       strapDone;
	logic [1:0] strapAddr;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strapCnt  <= 2'h0;
			strapDone <= 1'b0;
			strapAddr <= 2'h0;
		end else if (!strapDone) begin
			if (strapCnt == scpa_pkg::STRAP_DELAY) begin
				strapAddr <= {mosiS, ssS};
				strapDone <= 1'b1;
			end else begin
				strapCnt <= strapCnt + 2'h1;
			end
		end
	end

	// Mode select: sticky once three select falls are seen
	logic [1:0] ssFalls;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			spiMode <= 1'b0;
			ssFalls <= 2'h0;
		end else if (strapDone && !spiMode && ssP && !ssS) begin
			if (ssFalls == scpa_pkg::SPI_SWITCH_TOGGLES - 2'h1) begin
				spiMode <= 1'b1;
			end else begin
				ssFalls <= ssFalls + 2'h1;
			end
		end
	end

	// Bus events; each protocol is gated by the mode so only one is ever served
	logic sclRise, sclFall, startEv, stopEv, frameBeg, frameEnd, sampleEv, fallEv, dataIn;
	assign sclRise  = sclS && !sclP;
	assign sclFall  = !sclS && sclP;
	assign startEv  = !spiMode && sclS && sclP && sdaP && !sdaS;
	assign stopEv   = !spiMode && sclS && sclP && !sdaP && sdaS;
	assign frameBeg = spiMode && ssP && !ssS;
	assign frameEnd = spiMode && !ssP && ssS;
	assign sampleEv = sclRise && (!spiMode || !ssS);
	assign fallEv   = sclFall && (!spiMode || !ssS);
	assign dataIn   = spiMode ? mosiS : sdaS;

	scpa_pkg::scpa_state_t state;
	logic [3:0]  bitCnt;
	logic [7:0]  shiftReg;
	logic [1:0]  byteIdx;
	logic [1:0]  byteInWord;
	logic [15:0] subAddr;
	logic [23:0] wordBuf;
	logic        rwBit;
	logic        ackPhase;
	logic        txNext;
	logic        txLoad;

	// Byte decode
	logic [7:0]  rxByte;
	logic        byteDone;
	logic        isCtrl;
	logic [1:0]  lastByte;
	logic        wordLast;
	logic        pllRange;
	logic        subAllowed;
	logic        newSubAllowed;
	logic        writable;
	logic        ackOk;
	logic        goTx;
	logic        wordDone;
	logic [31:0] fullWord;
	logic        pushWord;
	logic [31:0] rdWord;
	logic [7:0]  txByte;

	function automatic logic allowedAt(input logic [15:0] addr, input logic locked);
		allowedAt = locked || (addr >= scpa_pkg::PLL_REG_FIRST && addr <= scpa_pkg::PLL_REG_LAST);
	endfunction

	assign rxByte        = {shiftReg[6:0], dataIn};
	assign byteDone      = state == scpa_pkg::SCPA_RX && sampleEv && bitCnt == scpa_pkg::BITS_PER_BYTE - 4'h1;
	assign isCtrl        = subAddr >= scpa_pkg::CTRL_REG_BASE;
	assign lastByte      = isCtrl ? scpa_pkg::CTRL_LAST_BYTE : scpa_pkg::MEM_LAST_BYTE;
	assign wordLast      = byteInWord == lastByte;
	assign pllRange      = subAddr >= scpa_pkg::PLL_REG_FIRST && subAddr <= scpa_pkg::PLL_REG_LAST;
	assign subAllowed    = allowedAt(subAddr, pllLocked);
	assign newSubAllowed = allowedAt({subAddr[15:8], rxByte}, pllLocked);
	assign writable      = subAllowed && (masterClockValid || pllRange);
	assign fullWord      = {wordBuf, rxByte};
	assign wordDone      = byteDone && byteIdx == scpa_pkg::DATA_BYTE_IDX && !rwBit && wordLast;
	assign pushWord      = wordDone && writable && subAddr != scpa_pkg::PAGE_SEL_REG;

	always_comb begin
		ackOk = 1'b1;
		if (byteIdx == scpa_pkg::CHIP_BYTE_IDX && !spiMode) begin
			ackOk = rxByte[7:1] == {scpa_pkg::CHIP_ADDR_PREFIX, strapAddr};
		end else if (byteIdx == scpa_pkg::SUB_LO_IDX) begin
			ackOk = newSubAllowed;
		end
	end

	assign goTx = spiMode ? (rwBit && byteIdx == scpa_pkg::SUB_LO_IDX) :
		(byteIdx == scpa_pkg::CHIP_BYTE_IDX && rxByte[0]);

	// Page register answers locally; blocked locations read as zero
	always_comb begin
		if (subAddr == scpa_pkg::PAGE_SEL_REG) begin
			rdWord = {31'h0, upperPageSelect};
		end else if (subAllowed) begin
			rdWord = rdData;
		end else begin
			rdWord = 32'h0;
		end
	end

	assign txByte = 8'(rdWord >> {lastByte - byteInWord, 3'b000});
	assign rdAddr = subAddr;
	assign rdPage = upperPageSelect;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state      <= scpa_pkg::SCPA_IDLE;
			bitCnt     <= 4'h0;
			shiftReg   <= 8'h00;
			byteIdx    <= scpa_pkg::CHIP_BYTE_IDX;
			byteInWord <= 2'h0;
			subAddr    <= 16'h0000;
			wordBuf    <= 24'h000000;
			rwBit      <= 1'b0;
			ackPhase   <= 1'b0;
			txNext     <= 1'b0;
			txLoad     <= 1'b0;
			sdaOut     <= 1'b0;
			sdaOe      <= 1'b0;
		end else if (stopEv || frameEnd) begin
			state  <= scpa_pkg::SCPA_IDLE;
			sdaOe  <= 1'b0;
			txLoad <= 1'b0;
		end else if (startEv || frameBeg) begin
			state   <= scpa_pkg::SCPA_RX;
			bitCnt  <= 4'h0;
			byteIdx <= scpa_pkg::CHIP_BYTE_IDX;
			sdaOe   <= 1'b0;
			txLoad  <= 1'b0;
		end else begin
			case (state)
				scpa_pkg::SCPA_RX: begin
					if (byteDone) begin
						bitCnt   <= 4'h0;
						shiftReg <= rxByte;
						txNext   <= goTx;
						ackPhase <= 1'b0;
						if (byteIdx != scpa_pkg::DATA_BYTE_IDX) begin
							byteIdx <= byteIdx + 2'h1;
						end
						case (byteIdx)
							scpa_pkg::CHIP_BYTE_IDX: rwBit <= rxByte[0];
							scpa_pkg::SUB_HI_IDX: subAddr[15:8] <= rxByte;
							scpa_pkg::SUB_LO_IDX: begin
								subAddr[7:0] <= rxByte;
								byteInWord   <= 2'h0;
							end
							default: begin
								wordBuf <= fullWord[23:0];
								if (wordLast) begin
									byteInWord <= 2'h0;
									subAddr    <= subAddr + 16'h0001;
								end else begin
									byteInWord <= byteInWord + 2'h1;
								end
							end
						endcase
						if (!ackOk) begin
							state <= scpa_pkg::SCPA_IDLE;
						end else if (spiMode) begin
							state <= goTx ? scpa_pkg::SCPA_TX : scpa_pkg::SCPA_RX;
						end else begin
							state <= scpa_pkg::SCPA_RXACK;
						end
					end else if (sampleEv) begin
						shiftReg <= rxByte;
						bitCnt   <= bitCnt + 4'h1;
					end
				end
				scpa_pkg::SCPA_RXACK: begin
					if (fallEv && !ackPhase) begin
						sdaOut   <= 1'b0;
						sdaOe    <= 1'b1;
						ackPhase <= 1'b1;
					end else if (fallEv) begin
						sdaOe  <= 1'b0;
						bitCnt <= 4'h0;
						txLoad <= txNext;
						state  <= txNext ? scpa_pkg::SCPA_TX : scpa_pkg::SCPA_RX;
					end
				end
				scpa_pkg::SCPA_TX: begin
					if (txLoad) begin
						txLoad   <= 1'b0;
						shiftReg <= {txByte[6:0], 1'b0};
						sdaOut   <= txByte[7];
						sdaOe    <= spiMode || !txByte[7];
						if (wordLast) begin
							byteInWord <= 2'h0;
							subAddr    <= subAddr + 16'h0001;
						end else begin
							byteInWord <= byteInWord + 2'h1;
						end
					end else if (sampleEv) begin
						bitCnt <= bitCnt + 4'h1;
					end else if (fallEv) begin
						if (bitCnt == 4'h0) begin
							txLoad <= 1'b1;
						end else if (bitCnt == scpa_pkg::BITS_PER_BYTE && spiMode) begin
							txLoad <= 1'b1;
							bitCnt <= 4'h0;
						end else if (bitCnt == scpa_pkg::BITS_PER_BYTE) begin
							sdaOe <= 1'b0;
							state <= scpa_pkg::SCPA_TXACK;
						end else begin
							shiftReg <= {shiftReg[6:0], 1'b0};
							sdaOut   <= shiftReg[7];
							sdaOe    <= spiMode || !shiftReg[7];
						end
					end
				end
				scpa_pkg::SCPA_TXACK: begin
					if (sampleEv) begin
						bitCnt <= 4'h0;
						state  <= sdaS ? scpa_pkg::SCPA_IDLE : scpa_pkg::SCPA_TX;
					end
				end
				default: begin
					sdaOe <= 1'b0;
				end
			endcase
		end
	end

	// Page register is served here since it steers the page of every later access
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			upperPageSelect <= scpa_pkg::PAGE_RESET;
		end else if (wordDone && writable && subAddr == scpa_pkg::PAGE_SEL_REG) begin
			upperPageSelect <= fullWord[0];
		end
	end

	// FIFO_DEPTH-entry write buffer (two by default); a full buffer stretches SCL, SPI cannot wait so drops
	logic [ENTRY_W-1:0] fifoMem [FIFO_DEPTH];
	logic [PTR_W-1:0]   fifoWp;
	logic [PTR_W-1:0]   fifoRp;
	logic [PTR_W:0]     fifoCnt;
	logic               fifoInReady;
	logic               pushEff;
	logic               popEff;

	assign fifoInReady = fifoCnt != (PTR_W + 1)'(FIFO_DEPTH);
	assign pushEff     = pushWord && fifoInReady;
	assign popEff      = wrValid && wrReady;
	assign wrValid     = fifoCnt != '0;
	assign {wrPage, wrIsCtrl, wrAddr, wrData} = fifoMem[fifoRp];

	always_ff @(posedge clk) begin
		if (pushEff) begin
			fifoMem[fifoWp] <= {upperPageSelect, isCtrl, subAddr, fullWord};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fifoWp    <= '0;
			fifoRp    <= '0;
			fifoCnt   <= '0;
			wrDropped <= 1'b0;
		end else begin
			wrDropped <= pushWord && !fifoInReady;
			if (pushEff) begin
				fifoWp <= fifoWp + PTR_W'(1);
			end
			if (popEff) begin
				fifoRp <= fifoRp + PTR_W'(1);
			end
			if (pushEff && !popEff) begin
				fifoCnt <= fifoCnt + (PTR_W + 1)'(1);
			end else if (popEff && !pushEff) begin
				fifoCnt <= fifoCnt - (PTR_W + 1)'(1);
			end
		end
	end

	// Stretch only while SCL is already low, so the master never sees a glitch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclOe <= 1'b0;
		end else begin
			sclOe <= !spiMode && state == scpa_pkg::SCPA_RX && byteIdx == scpa_pkg::DATA_BYTE_IDX &&
				bitCnt == 4'h0 && !rwBit && !fifoInReady && (sclOe || !sclS);
		end
	end

	assign sclOut   = 1'b0;
	assign portBusy = state != scpa_pkg::SCPA_IDLE;
endmodule

//--- tb/scpa_host_model.sv
`timescale 1ns/1ns
module scpa_host_model (
	output logic      mScl,
	output logic      mSda,
	output logic      mSs,
	output logic      mMosi,
	input  wire logic sclLine,
	input  wire logic sdaLine
);
	localparam int HALF = 160;
	bit spi;
	int stuck;
	initial begin
		mScl = 1'b1;
		mSda = 1'b1;
		mSs = 1'b1;
		mMosi = 1'b0;
		spi = 1'b0;
		stuck = 0;
	end
	// Bounded wait: device may stretch SCL while its buffer is full
	task automatic sclUp();
		int n;
		n = 0;
		mScl = 1'b1;
		while (sclLine !== 1'b1 && n < 2000) begin
			#10;
			n++;
		end
		if (n >= 2000) stuck++;
		#(HALF - 20);
	endtask
	// Sampled late in the high phase, device changes data only after the fall
	task automatic bitIo(input logic b, output logic r);
		mScl = 1'b0;
		#40;
		if (spi) mMosi = b;
		else mSda = b;
		#(HALF - 40);
		sclUp();
		r = sdaLine;
		#20;
	endtask
	task automatic xfer(input logic [7:0] b, input logic mAck, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bitIo(b[i], r[i]);
		ack = 1'b0;
		if (!spi) bitIo(mAck, ack);
	endtask
	task automatic edgeCond(input logic from);
		mScl = 1'b0;
		#40;
		mSda = from;
		#(HALF - 40);
		sclUp();
		mSda = !from;
		#HALF;
	endtask
	task automatic start();
		edgeCond(1'b1);
	endtask
	task automatic stop();
		edgeCond(1'b0);
	endtask
	task automatic spiToggle();
		mSs = 1'b0;
		#200;
		mSs = 1'b1;
		#200;
	endtask
	// Deselected MOSI does not keep its last value
	task automatic spiSel(input logic lvl);
		mSs = lvl;
		if (lvl) mMosi = !mMosi;
		#HALF;
	endtask
endmodule

//--- tb/scpa_slave_port_assertions.sv
`timescale 1ns/1ns
module scpa_slave_port_chk (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        sclOe,
	input wire logic        pllLocked,
	input wire logic        masterClockValid,
	input wire logic        wrValid,
	input wire logic        wrReady,
	input wire logic [15:0] wrAddr,
	input wire logic        wrPage,
	input wire logic        wrIsCtrl,
	input wire logic [31:0] wrData,
	input wire logic        wrDropped,
	input wire logic        spiMode,
	input wire logic        upperPageSelect
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic pllWin = wrAddr >= scpa_pkg::PLL_REG_FIRST && wrAddr <= scpa_pkg::PLL_REG_LAST;

	property p_i2c_after_reset; $fell(sys_rst) |-> !spiMode; endproperty
	a_i2c_after_reset: assert property (p_i2c_after_reset) else $error("port not in I2C after reset");
	property p_spi_sticky; spiMode |=> spiMode; endproperty
	a_spi_sticky: assert property (p_spi_sticky) else $error("SPI mode left");
	property p_no_stretch_spi; spiMode |-> !sclOe; endproperty
	a_no_stretch_spi: assert property (p_no_stretch_spi) else $error("I2C stretch in SPI mode");
	property p_hold_word;
		wrValid && !wrReady |=> wrValid && $stable(wrAddr) && $stable(wrData) && $stable(wrIsCtrl) && $stable(wrPage);
	endproperty
	a_hold_word: assert property (p_hold_word) else $error("stalled word changed");
	property p_word_kind; wrValid |-> wrIsCtrl == (wrAddr >= scpa_pkg::CTRL_REG_BASE); endproperty
	a_word_kind: assert property (p_word_kind) else $error("word kind wrong for address");
	property p_lock_gate; $rose(wrValid) && !pllLocked |-> pllWin; endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("write outside PLL range before lock");
	property p_clock_gate; $rose(wrValid) && !masterClockValid |-> pllWin; endproperty
	a_clock_gate: assert property (p_clock_gate) else $error("write without master clock");
	property p_word_page; $rose(wrValid) |-> wrPage == upperPageSelect; endproperty
	a_word_page: assert property (p_word_page) else $error("word tagged with wrong page");
	property p_drop_full; wrDropped |-> spiMode && wrValid ##1 !wrDropped; endproperty
	a_drop_full: assert property (p_drop_full) else $error("drop without full buffer");

	c_drop: cover property (wrDropped);
	c_spi: cover property ($rose(spiMode));
	c_ctrl: cover property (wrValid && wrReady && wrIsCtrl);
	c_mem: cover property (wrValid && wrReady && !wrIsCtrl);
	c_stretch: cover property ($rose(sclOe));
endmodule

bind scpa_slave_port scpa_slave_port_chk u_chk (.clk(clk), .sys_rst(sys_rst), .sclOe(sclOe), .pllLocked(pllLocked),
	.masterClockValid(masterClockValid), .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrPage(wrPage),
	.wrIsCtrl(wrIsCtrl), .wrData(wrData), .wrDropped(wrDropped), .spiMode(spiMode), .upperPageSelect(upperPageSelect));

//--- tb/scpa_slave_port_tb.sv
`timescale 1ns/1ns
module scpa_slave_port_tb;
	logic        clk, sys_rst, sclOut, sclOe, sdaOut, sdaOe, pllLocked, masterClockValid, wrValid, wrReady;
	logic        wrIsCtrl, wrPage, wrDropped, rdPage, spiMode, upperPageSelect, portBusy, mScl, mSda, mSs, mMosi;
	logic        stall, page;
	logic [15:0] wrAddr, rdAddr;
	logic [31:0] wrData, rdData;
	logic [49:0] gotQ[$], expQ[$];
	int          errors, compares, dropCount, cyc, seed, n;
	wire logic   sclLine = mScl & ~sclOe;
	wire logic   sdaLine = mSda & ~(sdaOe & ~sdaOut);

	function automatic logic [31:0] rdModel(input logic [15:0] a, input logic p);
		return {a ^ {16{p}}, ~a};
	endfunction
	assign rdData = rdModel(rdAddr, rdPage);

	scpa_slave_port u_dut (.clk(clk), .sys_rst(sys_rst), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .selectOrStrapZeroPin(mSs), .serialInOrStrapOnePin(mMosi),
		.pllLocked(pllLocked), .masterClockValid(masterClockValid), .wrValid(wrValid), .wrReady(wrReady),
		.wrAddr(wrAddr), .wrPage(wrPage), .wrIsCtrl(wrIsCtrl), .wrData(wrData), .wrDropped(wrDropped),
		.rdAddr(rdAddr), .rdPage(rdPage), .rdData(rdData), .spiMode(spiMode), .upperPageSelect(upperPageSelect),
		.portBusy(portBusy));
	scpa_host_model u_host (.mScl(mScl), .mSda(mSda), .mSs(mSs), .mMosi(mMosi), .sclLine(sclLine), .sdaLine(sdaLine));

	initial clk = 1'b0;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		#1;
		wrReady = stall ? 1'b0 : 1'($random(seed));
	end
	always @(posedge clk) begin
		if (wrValid === 1'b1 && wrReady === 1'b1) gotQ.push_back({wrPage, wrIsCtrl, wrAddr, wrData});
		if (wrDropped === 1'b1) dropCount++;
		cyc++;
		if (cyc == 60000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] a);
		compares++;
		if (a !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, a);
		end
	endtask
	task automatic i2cWr(input logic [7:0] b[$], input bit stp, output int k);
		logic [7:0] r;
		logic       a;
		k = 0;
		u_host.start();
		foreach (b[i]) begin
			u_host.xfer(b[i], 1'b1, r, a);
			if (a !== 1'b0) break;
			k++;
		end
		if (stp) u_host.stop();
	endtask
	task automatic burst(input logic [15:0] a, input int words);
		logic [7:0]  b[$];
		logic [7:0]  r;
		logic [15:0] s;
		logic [31:0] d;
		logic        k;
		int          acks;
		b = '{8'h72, a[15:8], a[7:0]};
		for (int w = 0; w < words; w++) begin
			s = a + 16'(w);
			d = $random(seed);
			if (s >= 16'hf000) d[31:16] = 16'h0000;
			expQ.push_back({page, s >= 16'hf000, s, d});
			for (int j = (s >= 16'hf000 ? 1 : 3); j >= 0; j--) b.push_back(d[8*j +: 8]);
		end
		if (u_host.spi) begin
			u_host.spiSel(1'b0);
			chk("busy", 32'h1, 32'(portBusy));
			foreach (b[i]) u_host.xfer(b[i], 1'b1, r, k);
			u_host.spiSel(1'b1);
			chk("busy", 32'h0, 32'(portBusy));
		end else begin
			i2cWr(b, 1'b1, acks);
			chk("acks", b.size(), acks);
		end
	endtask
	task automatic drain();
		logic [49:0] e, g;
		int          t;
		t = 0;
		while (gotQ.size() < expQ.size() && t < 2000) begin
			tick(1);
			t++;
		end
		chk("words", expQ.size(), gotQ.size());
		while (expQ.size() > 0 && gotQ.size() > 0) begin
			e = expQ.pop_front();
			g = gotQ.pop_front();
			chk("page kind addr", 32'(e[49:32]), 32'(g[49:32]));
			chk("data", e[31:0], g[31:0] & (e[48] ? 32'h0000ffff : 32'hffffffff));
		end
		expQ.delete();
		gotQ.delete();
	endtask
	task automatic i2cRd(input logic [15:0] a);
		logic [7:0]  r;
		logic [63:0] v;
		logic        k;
		int          acks;
		if (u_host.spi) begin
			u_host.spiSel(1'b0);
			u_host.xfer(8'h73, 1'b1, r, k);
			u_host.xfer(a[15:8], 1'b1, r, k);
			u_host.xfer(a[7:0], 1'b1, r, k);
		end else begin
			i2cWr('{8'h72, a[15:8], a[7:0]}, 1'b0, acks);
			u_host.start();
			u_host.xfer(8'h73, 1'b1, r, k);
			chk("read ack", 32'h0, 32'(k));
		end
		for (int i = 7; i >= 0; i--) begin
			u_host.xfer(8'hff, 1'(i == 0), r, k);
			v[8*i +: 8] = r;
		end
		if (u_host.spi) u_host.spiSel(1'b1);
		else u_host.stop();
		chk("rd0", rdModel(a, page), v[63:32]);
		chk("rd1", rdModel(a + 16'h0001, page), v[31:0]);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		seed = 67;
		{errors, compares, dropCount, cyc} = '0;
		{stall, page, wrReady, pllLocked, masterClockValid} = '0;
		sys_rst = 1'b1;
		tick(10);
		sys_rst = 1'b0;
		tick(1);
		chk("spiMode", 32'h0, 32'(spiMode));
		chk("page", 32'h0, 32'(upperPageSelect));
		tick(8);
		i2cWr('{8'h72, 8'h00, 8'h10, 8'haa}, 1'b1, n);
		chk("acks before lock", 32'h2, n);
		burst(16'hf002, 1);
		drain();
		i2cWr('{8'h74, 8'h00, 8'h10}, 1'b1, n);
		chk("acks other chip", 32'h0, n);
		tick(1);
		{pllLocked, masterClockValid} = 2'b11;
		i2cWr('{8'h72, 8'hf8, 8'h99, 8'h00, 8'h01}, 1'b1, n);
		page = 1'b1;
		chk("page", 32'h1, 32'(upperPageSelect));
		burst(16'heffe, 3);
		drain();
		repeat (3) begin
			burst(16'($random(seed)) & 16'hf7ff, 2);
			drain();
		end
		// Core stalls: third word must wait on a stretched SCL, not be lost
		stall = 1'b1;
		fork
			burst(16'h0040, 3);
			begin
				tick(1000);
				chk("stretch", 32'h1, 32'(sclOe));
				stall = 1'b0;
			end
		join
		drain();
		// Half a word then stop, then a full word without master clock
		i2cWr('{8'h72, 8'h00, 8'h20, 8'h11, 8'h22}, 1'b1, n);
		tick(1);
		chk("idle", 32'h0, 32'(portBusy));
		masterClockValid = 1'b0;
		i2cWr('{8'h72, 8'h01, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, n);
		chk("acks no clock", 32'h7, n);
		tick(20);
		masterClockValid = 1'b1;
		chk("no words", 32'h0, gotQ.size());
		i2cRd(16'($random(seed)) & 16'h7ffe);
		repeat (2) u_host.spiToggle();
		tick(6);
		chk("spiMode", 32'h0, 32'(spiMode));
		u_host.spiToggle();
		tick(6);
		chk("spiMode", 32'h1, 32'(spiMode));
		u_host.spi = 1'b1;
		stall = 1'b1;
		burst(16'hf400, 3);
		chk("drops", 32'h1, dropCount);
		void'(expQ.pop_back());
		stall = 1'b0;
		drain();
		chk("spiMode", 32'h1, 32'(spiMode));
		i2cRd(16'($random(seed)) & 16'h7ffe);
		chk("scl stuck", 32'h0, u_host.stuck);
		// Mid-run reset drops the sticky SPI mode
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		tick(1);
		chk("spiMode", 32'h0, 32'(spiMode));
		chk("page", 32'h0, 32'(upperPageSelect));
		chk("busy", 32'h0, 32'(portBusy));
		tally_and_finish();
	end
endmodule
